// ==== verilog/sadr_pkg.sv ====
// Package for the speaker amplifier and ADC dither register bank.
// Assumes an 8-bit register port driven by the control interface on mclk_in.
// Behaviour
// - Left speaker gain in bits 7:6 selects 0, 6, 12 or 18 dB; read/write.
// - Right speaker gain in bits 5:4 selects 0, 6, 12 or 18 dB; read/write.
// - Bit 3 write-only: 0 shuts left channel down, 1 enables; resets 0.
// - Bit 2 write-only: 0 shuts right channel down, 1 enables; resets 0.
// - Left dither bits 7:4 sign-magnitude, 15 mV steps to 105 mV; resets 0000.
// - Right dither bits 3:0, same sign-magnitude encoding.
// - Dither disabled whenever a channel's magnitude bits are zero.
package sadr_pkg;
    localparam logic [7:0] SADR_ADDR_RSVD72  = 8'h48;
    localparam logic [7:0] SADR_ADDR_SPK     = 8'h49;
    localparam logic [7:0] SADR_ADDR_RSVD74  = 8'h4A;
    localparam logic [7:0] SADR_ADDR_RSVD75  = 8'h4B;
    localparam logic [7:0] SADR_ADDR_DITHER  = 8'h4C;
    localparam logic [7:0] SADR_ADDR_RSVD77  = 8'h4D;
    localparam logic [7:0] SADR_ADDR_RSVD78  = 8'h4E;
    localparam logic [7:0] SADR_RSVD_VALUE   = 8'h00;
    localparam int         SADR_LGAIN_LSB    = 6;
    localparam int         SADR_RGAIN_LSB    = 4;
    localparam int         SADR_LEN_BIT      = 3;
    localparam int         SADR_REN_BIT      = 2;
    localparam int         SADR_LDITH_LSB    = 4;
    localparam int         SADR_RDITH_LSB    = 0;
    localparam logic [1:0] SADR_GAIN_RESET   = 2'h0;
    localparam logic       SADR_EN_RESET     = 1'b0;
    localparam logic [3:0] SADR_DITH_RESET   = 4'h0;
    localparam int         SADR_DITH_STEP_MV = 15;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sadr_req_t;

    typedef struct packed {
        logic [1:0] gain;
        logic       enable;
        logic       dith_neg;
        logic [2:0] dith_mag;
        logic       dith_on;
    } sadr_chan_t;
endpackage : sadr_pkg

// ==== verilog/sadr_dither_dec.sv ====
// Decodes one 4-bit sign-magnitude dither field.
// Assumes the field comes from a register on the same clock.
`timescale 1ns/100ps
module sadr_dither_dec
    import sadr_pkg::*;
(
    input  wire logic [3:0] field_in,
    output logic            neg_out,
    output logic [2:0]      mag_out,
    output logic            on_out
);
    always_comb
    begin
        neg_out = field_in[3];
        mag_out = field_in[2:0];
        on_out  = (field_in[2:0] != 3'h0);
    end
endmodule : sadr_dither_dec

// ==== verilog/sadr_regs.sv ====
// Register bank for speaker amplifier gain/enable and ADC DC dither.
// Assumes a synchronous one-cycle register port on mclk_in from the control bus.
`timescale 1ns/100ps
module sadr_regs
    import sadr_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    input  wire sadr_req_t  req_in,
    output logic [7:0]      rdata_out,
    output logic            rvalid_out,
    output sadr_chan_t      left_out,
    output sadr_chan_t      right_out
);
    typedef struct packed {
        logic [1:0] lgain;
        logic [1:0] rgain;
        logic       len;
        logic       ren;
        logic [3:0] ldith;
        logic [3:0] rdith;
        logic [7:0] rdata;
        logic       rvalid;
        sadr_chan_t left;
        sadr_chan_t right;
    } sadr_state_t;

    localparam sadr_state_t SADR_STATE_RESET = '{
        lgain:  SADR_GAIN_RESET,
        rgain:  SADR_GAIN_RESET,
        len:    SADR_EN_RESET,
        ren:    SADR_EN_RESET,
        ldith:  SADR_DITH_RESET,
        rdith:  SADR_DITH_RESET,
        rdata:  SADR_RSVD_VALUE,
        rvalid: 1'b0,
        left:   '0,
        right:  '0
    };

    sadr_state_t s_q;
    sadr_state_t s_d;
    logic        l_neg;
    logic [2:0]  l_mag;
    logic        l_on;
    logic        r_neg;
    logic [2:0]  r_mag;
    logic        r_on;

    sadr_dither_dec u_ldec
    (
        .field_in (s_q.ldith),
        .neg_out  (l_neg),
        .mag_out  (l_mag),
        .on_out   (l_on)
    );

    sadr_dither_dec u_rdec
    (
        .field_in (s_q.rdith),
        .neg_out  (r_neg),
        .mag_out  (r_mag),
        .on_out   (r_on)
    );

    // Decode, read views and channel images are locals of the one next-state process
    always_comb
    begin : next_state
        logic        hit_spk;
        logic        hit_dither;
        logic        wr_spk;
        logic        wr_dither;
        logic [7:0]  spk_view;
        logic [7:0]  dither_view;
        logic [7:0]  rd_mux;
        sadr_chan_t  left_img;
        sadr_chan_t  right_img;

        hit_spk     = 1'b0;
        hit_dither  = 1'b0;
        wr_spk      = 1'b0;
        wr_dither   = 1'b0;
        spk_view    = '0;
        dither_view = '0;
        rd_mux      = SADR_RSVD_VALUE;
        left_img    = '0;
        right_img   = '0;
        s_d         = s_q;
        s_d.rvalid  = req_in.rd;

        case (req_in.addr)
            SADR_ADDR_SPK:
            begin
                hit_spk = 1'b1;
            end
            SADR_ADDR_DITHER:
            begin
                hit_dither = 1'b1;
            end
            SADR_ADDR_RSVD72,
            SADR_ADDR_RSVD74,
            SADR_ADDR_RSVD75,
            SADR_ADDR_RSVD77,
            SADR_ADDR_RSVD78:
            begin
                // Read-only zero; a write here changes nothing
                hit_spk    = 1'b0;
                hit_dither = 1'b0;
            end
            default:
            begin
                hit_spk    = 1'b0;
                hit_dither = 1'b0;
            end
        endcase
        wr_spk    = req_in.wr && hit_spk;
        wr_dither = req_in.wr && hit_dither;

        if (wr_spk)
        begin
            s_d.lgain = req_in.wdata[SADR_LGAIN_LSB +: 2];
            s_d.rgain = req_in.wdata[SADR_RGAIN_LSB +: 2];
            s_d.len   = req_in.wdata[SADR_LEN_BIT];
            s_d.ren   = req_in.wdata[SADR_REN_BIT];
            // Bits 1:0 are not stored; host keeps them zero
        end
        if (wr_dither)
        begin
            s_d.ldith = req_in.wdata[SADR_LDITH_LSB +: 4];
            s_d.rdith = req_in.wdata[SADR_RDITH_LSB +: 4];
        end

        // Views come from s_q, so a read beside a write returns the old contents
        spk_view[SADR_LGAIN_LSB +: 2]    = s_q.lgain;
        spk_view[SADR_RGAIN_LSB +: 2]    = s_q.rgain;
        dither_view[SADR_LDITH_LSB +: 4] = s_q.ldith;
        dither_view[SADR_RDITH_LSB +: 4] = s_q.rdith;
        // Enable bits are write-only and bits 1:0 unstored: both read zero
        if (hit_spk)
        begin
            rd_mux = spk_view;
        end
        else if (hit_dither)
        begin
            rd_mux = dither_view;
        end
        else
        begin
            rd_mux = SADR_RSVD_VALUE;
        end
        if (req_in.rd)
        begin
            s_d.rdata = rd_mux;
        end

        // Outputs registered so the analog side sees glitch-free levels
        left_img.gain      = s_q.lgain;
        left_img.enable    = s_q.len;
        left_img.dith_neg  = l_neg;
        left_img.dith_mag  = l_mag;
        left_img.dith_on   = l_on;
        right_img.gain     = s_q.rgain;
        right_img.enable   = s_q.ren;
        right_img.dith_neg = r_neg;
        right_img.dith_mag = r_mag;
        right_img.dith_on  = r_on;
        s_d.left           = left_img;
        s_d.right          = right_img;
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_q <= SADR_STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_out  = s_q.rdata;
    assign rvalid_out = s_q.rvalid;
    assign left_out   = s_q.left;
    assign right_out  = s_q.right;
endmodule : sadr_regs

// ==== test/sadr_regs_monitor.sv ====
// Checker for the speaker and dither register bank.
// Assumes the bind below attaches it to every sadr_regs.
`timescale 1ns/100ps
module sadr_regs_monitor
    import sadr_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       rst_b_in,
    input wire sadr_req_t  req_in,
    input wire logic [7:0] rdata_out,
    input wire logic       rvalid_out,
    input wire sadr_chan_t left_out,
    input wire sadr_chan_t right_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    logic       ws, wd, rs;
    logic [7:0] wv;
    assign wv = req_in.wdata;
    assign ws = req_in.wr && req_in.addr == SADR_ADDR_SPK;
    assign wd = req_in.wr && req_in.addr == SADR_ADDR_DITHER;
    assign rs = req_in.rd && req_in.addr != SADR_ADDR_SPK && req_in.addr != SADR_ADDR_DITHER;
    property p_lg; ws |=> ##1 left_out.gain == $past(wv[7:6], 2); endproperty
    a_lg: assert property (p_lg) else $error("left gain");
    property p_rg; ws |=> ##1 right_out.gain == $past(wv[5:4], 2); endproperty
    a_rg: assert property (p_rg) else $error("right gain");
    property p_le; ws |=> ##1 left_out.enable == $past(wv[3], 2); endproperty
    a_le: assert property (p_le) else $error("left enable");
    property p_re; ws |=> ##1 right_out.enable == $past(wv[2], 2); endproperty
    a_re: assert property (p_re) else $error("right enable");
    property p_ld;
        wd |=> ##1 {left_out.dith_neg, left_out.dith_mag} == $past(wv[7:4], 2);
    endproperty
    a_ld: assert property (p_ld) else $error("left dither");
    property p_rd;
        wd |=> ##1 {right_out.dith_neg, right_out.dith_mag} == $past(wv[3:0], 2);
    endproperty
    a_rd: assert property (p_rd) else $error("right dither");
    property p_on;
        left_out.dith_on == |left_out.dith_mag && right_out.dith_on == |right_out.dith_mag;
    endproperty
    a_on: assert property (p_on) else $error("dither on");
    property p_rs; rs |=> rvalid_out && rdata_out == 8'h00; endproperty
    a_rs: assert property (p_rs) else $error("reserved read");
    property p_sp;
        req_in.rd && req_in.addr == SADR_ADDR_SPK |=> rdata_out[3:0] == 4'h0;
    endproperty
    a_sp: assert property (p_sp) else $error("speaker read");
    cover property (ws);
    cover property (wd);
    cover property (rs);
endmodule : sadr_regs_monitor

bind sadr_regs sadr_regs_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .left_out(left_out), .right_out(right_out));

// ==== test/sadr_regs_bench.sv ====
// Random register traffic checked against a reference model.
// Assumes sadr_pkg and sadr_regs are compiled first.
`timescale 1ns/100ps
module sadr_regs_bench;
    import sadr_pkg::*;
    logic        mclk_in, rst_b_in, rv;
    sadr_req_t   req_in, nx;
    logic [7:0]  rdata_out, spk, dit, ex, rq;
    sadr_chan_t  left_out, right_out;
    logic [31:0] r;
    int          n_errors, n_tests;
    sadr_regs DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req_in),
        .rdata_out(rdata_out), .rvalid_out(rv), .left_out(left_out), .right_out(right_out));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic test_done;
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial
    begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial
    begin
        {n_errors, n_tests} = '0;
        r = 32'hB5A7EE97;
        // Second pass reasserts reset over live state, so reset values are checked
        repeat (2)
        begin
            rst_b_in = 1'b0;
            req_in = '0;
            {spk, dit, rq} = '0;
            repeat (3) @(posedge mclk_in);
            @(negedge mclk_in);
            rst_b_in = 1'b1;
            repeat (200)
            begin
                r = lfsr(r);
                nx = {r[1:0], 5'h09, r[10:8], r[23:16]};
                if (nx.addr == SADR_ADDR_SPK) nx.wdata[1:0] = 2'h0;
                if (nx.addr inside {SADR_ADDR_RSVD72, SADR_ADDR_RSVD74, SADR_ADDR_RSVD75,
                    SADR_ADDR_RSVD77, SADR_ADDR_RSVD78}) nx.wr = 1'b0;
                req_in = nx;
                ex = req_in.addr == SADR_ADDR_SPK ? {spk[7:4], 4'h0} : SADR_RSVD_VALUE;
                if (req_in.addr == SADR_ADDR_DITHER) ex = dit;
                if (req_in.rd) rq = ex;
                @(negedge mclk_in);
                // Outputs lag one request, so the model updates after the checks
                chk({rv, rdata_out}, {req_in.rd, rq});
                chk(left_out, {spk[7:6], spk[3], dit[7:4], |dit[6:4]});
                chk(right_out, {spk[5:4], spk[2], dit[3:0], |dit[2:0]});
                if (req_in.wr && req_in.addr == SADR_ADDR_SPK) spk = req_in.wdata;
                if (req_in.wr && req_in.addr == SADR_ADDR_DITHER) dit = req_in.wdata;
            end
        end
        test_done();
    end
endmodule : sadr_regs_bench
